/* logic/nco_output_and_control.sv */
// numerically controlled oscillator: register port, clock select, flag and output stage
// assumes the four input-clock ticks are one-cycle pulses synchronous to clk_sys
//
// Contract
// - pulse width 1 to 128 periods, pulse mode
// - polarity bit 4 inverts final output
// - polarity change raises the overflow flag when the overflow interrupt is enabled
// - bit 5 reads current output level
// - every overflow sets the overflow flag
// - interrupt needs four enable bits set
// - any reset clears all registers
// - runs on input clock, ignores sleep
// - fast oscillator kept on when selected and module on
// - control bit 0 selects pulse mode
// - two-bit field selects input clock
// - unimplemented bits read zero, ignore writes
// - accumulator low byte readable and writable
// - accumulator adds increment each input edge
// - fixed duty mode toggles on overflow
// - pulse starts on edge after overflow
// - increment double buffered, low byte loads
`timescale 1ns/1ps
`include "nco_params.svh"
module nco_output_and_control #(
    parameter int ACC_W = 20,
    parameter int INC_W = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register port
    input wire logic [`NCO_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // input clock ticks, one per rising edge of each source
    input wire logic tick_ext_pin,
    input wire logic tick_sys_osc,
    input wire logic tick_fast_osc,
    input wire logic tick_logic_cell,
    // oscillator output
    output logic nco_out,
    output logic nco_pin_o,
    output logic nco_pin_oe,
    // interrupt and power
    output logic irq_out,
    output logic keep_fast_osc_on
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic module_on_q, module_on_d;
    logic pin_drive_on_q, pin_drive_on_d;
    logic output_polarity_q, output_polarity_d;
    logic pulse_mode_select_q, pulse_mode_select_d;
    logic [2:0] pulse_width_select_q, pulse_width_select_d;
    nco_types_pkg::clk_sel_e input_clock_select_q, input_clock_select_d;
    logic overflow_flag_q, overflow_flag_d;
    logic overflow_irq_enable_q, overflow_irq_enable_d;
    logic peripheral_irq_enable_q, peripheral_irq_enable_d;
    logic global_irq_enable_q, global_irq_enable_d;
    logic [7:0] inc_low_q, inc_low_d;
    logic [7:0] inc_high_q, inc_high_d;
    logic inc_arm_q, inc_arm_d;
    logic [7:0] rdata_q, rdata_d;

    logic tick;
    logic overflow;
    logic raw_out;
    logic [ACC_W-1:0] acc_value;
    logic [2:0] acc_wr;
    logic wr_ctrl;
    logic wr_flag;
    logic pol_event;

    // ----------------------------------------------------------------
    // input clock select
    // ----------------------------------------------------------------
    always_comb begin
        case (input_clock_select_q)
            nco_types_pkg::CLK_EXT_PIN: tick = tick_ext_pin;
            nco_types_pkg::CLK_SYS_OSC: tick = tick_sys_osc;
            nco_types_pkg::CLK_FAST_OSC: tick = tick_fast_osc;
            nco_types_pkg::CLK_LOGIC_CELL: tick = tick_logic_cell;
            default: tick = 1'b0;
        endcase
    end

    // fast oscillator request holds whatever the cpu sleep state is
    assign keep_fast_osc_on = module_on_q && (input_clock_select_q == nco_types_pkg::CLK_FAST_OSC);

    // ----------------------------------------------------------------
    // register writes and reads
    // ----------------------------------------------------------------
    assign wr_ctrl = reg_wr && (reg_addr == `NCO_OFS_CONTROL);
    assign wr_flag = reg_wr && (reg_addr == `NCO_OFS_FLAG_REG);
    assign pol_event = wr_ctrl && (reg_wdata[`NCO_BIT_OUTPUT_POLARITY] != output_polarity_q)
        && overflow_irq_enable_q;
    assign acc_wr = {reg_wr && (reg_addr == `NCO_OFS_ACCUM_UPPER),
                     reg_wr && (reg_addr == `NCO_OFS_ACCUM_HIGH),
                     reg_wr && (reg_addr == `NCO_OFS_ACCUM_LOW)};

    always_comb begin
        module_on_d = module_on_q;
        pin_drive_on_d = pin_drive_on_q;
        output_polarity_d = output_polarity_q;
        pulse_mode_select_d = pulse_mode_select_q;
        pulse_width_select_d = pulse_width_select_q;
        input_clock_select_d = input_clock_select_q;
        overflow_flag_d = overflow_flag_q;
        overflow_irq_enable_d = overflow_irq_enable_q;
        peripheral_irq_enable_d = peripheral_irq_enable_q;
        global_irq_enable_d = global_irq_enable_q;
        inc_low_d = inc_low_q;
        inc_high_d = inc_high_q;
        inc_arm_d = 1'b0;
        rdata_d = `NCO_RST_BYTE;
        if (reg_wr) begin
            case (reg_addr)
                `NCO_OFS_CONTROL: begin
                    module_on_d = reg_wdata[`NCO_BIT_MODULE_ON];
                    pin_drive_on_d = reg_wdata[`NCO_BIT_PIN_DRIVE_ON];
                    output_polarity_d = reg_wdata[`NCO_BIT_OUTPUT_POLARITY];
                    pulse_mode_select_d = reg_wdata[`NCO_BIT_PULSE_MODE];
                end
                `NCO_OFS_CLOCK_CONTROL: begin
                    pulse_width_select_d = reg_wdata[`NCO_PWS_MSB:`NCO_PWS_LSB];
                    input_clock_select_d =
                        nco_types_pkg::clk_sel_e'(reg_wdata[`NCO_CKS_MSB:`NCO_CKS_LSB]);
                end
                `NCO_OFS_INC_LOW: begin
                    inc_low_d = reg_wdata;
                    inc_arm_d = module_on_q;
                end
                `NCO_OFS_INC_HIGH: begin
                    inc_high_d = reg_wdata;
                end
                `NCO_OFS_FLAG_REG: begin
                    overflow_flag_d = reg_wdata[`NCO_BIT_OVERFLOW_FLAG];
                end
                `NCO_OFS_ENABLE_REG: begin
                    overflow_irq_enable_d = reg_wdata[`NCO_BIT_OVERFLOW_IE];
                end
                `NCO_OFS_IRQ_CONTROL: begin
                    global_irq_enable_d = reg_wdata[`NCO_BIT_GLOBAL_IE];
                    peripheral_irq_enable_d = reg_wdata[`NCO_BIT_PERIPH_IE];
                end
                default: begin
                end
            endcase
        end
        // hardware set wins over a software clear in the same cycle
        if (overflow || pol_event) begin
            overflow_flag_d = 1'b1;
        end
        if (reg_rd) begin
            case (reg_addr)
                `NCO_OFS_CONTROL: begin
                    rdata_d[`NCO_BIT_MODULE_ON] = module_on_q;
                    rdata_d[`NCO_BIT_PIN_DRIVE_ON] = pin_drive_on_q;
                    rdata_d[`NCO_BIT_OUTPUT_LEVEL] = nco_out;
                    rdata_d[`NCO_BIT_OUTPUT_POLARITY] = output_polarity_q;
                    rdata_d[`NCO_BIT_PULSE_MODE] = pulse_mode_select_q;
                end
                `NCO_OFS_CLOCK_CONTROL: begin
                    rdata_d[`NCO_PWS_MSB:`NCO_PWS_LSB] = pulse_width_select_q;
                    rdata_d[`NCO_CKS_MSB:`NCO_CKS_LSB] = input_clock_select_q;
                end
                `NCO_OFS_ACCUM_LOW: rdata_d = acc_value[7:0];
                `NCO_OFS_ACCUM_HIGH: rdata_d = acc_value[15:8];
                `NCO_OFS_ACCUM_UPPER: rdata_d[3:0] = acc_value[19:16];
                `NCO_OFS_INC_LOW: rdata_d = inc_low_q;
                `NCO_OFS_INC_HIGH: rdata_d = inc_high_q;
                `NCO_OFS_FLAG_REG: rdata_d[`NCO_BIT_OVERFLOW_FLAG] = overflow_flag_q;
                `NCO_OFS_ENABLE_REG: rdata_d[`NCO_BIT_OVERFLOW_IE] = overflow_irq_enable_q;
                `NCO_OFS_IRQ_CONTROL: begin
                    rdata_d[`NCO_BIT_GLOBAL_IE] = global_irq_enable_q;
                    rdata_d[`NCO_BIT_PERIPH_IE] = peripheral_irq_enable_q;
                end
                default: rdata_d = `NCO_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            module_on_q <= 1'b0;
            pin_drive_on_q <= 1'b0;
            output_polarity_q <= 1'b0;
            pulse_mode_select_q <= 1'b0;
            pulse_width_select_q <= 3'h0;
            input_clock_select_q <= nco_types_pkg::CLK_EXT_PIN;
            overflow_flag_q <= 1'b0;
            overflow_irq_enable_q <= 1'b0;
            peripheral_irq_enable_q <= 1'b0;
            global_irq_enable_q <= 1'b0;
            inc_low_q <= `NCO_RST_BYTE;
            inc_high_q <= `NCO_RST_BYTE;
            inc_arm_q <= 1'b0;
            rdata_q <= `NCO_RST_BYTE;
        end else begin
            module_on_q <= module_on_d;
            pin_drive_on_q <= pin_drive_on_d;
            output_polarity_q <= output_polarity_d;
            pulse_mode_select_q <= pulse_mode_select_d;
            pulse_width_select_q <= pulse_width_select_d;
            input_clock_select_q <= input_clock_select_d;
            overflow_flag_q <= overflow_flag_d;
            overflow_irq_enable_q <= overflow_irq_enable_d;
            peripheral_irq_enable_q <= peripheral_irq_enable_d;
            global_irq_enable_q <= global_irq_enable_d;
            inc_low_q <= inc_low_d;
            inc_high_q <= inc_high_d;
            inc_arm_q <= inc_arm_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ----------------------------------------------------------------
    // datapath: accumulator runs only on input clock ticks, never on cpu state
    // ----------------------------------------------------------------
    nco_accum #(
        .ACC_W(ACC_W),
        .INC_W(INC_W)
    ) u_accum (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .tick(tick),
        .module_on(module_on_q),
        .inc_value({inc_high_q, inc_low_q}),
        .inc_arm(inc_arm_q),
        .acc_wr(acc_wr),
        .acc_wdata(reg_wdata),
        .acc_value(acc_value),
        .overflow(overflow)
    );

    nco_pulse u_pulse (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .tick(tick),
        .module_on(module_on_q),
        .pulse_mode_select(pulse_mode_select_q),
        .pulse_width_select(pulse_width_select_q),
        .overflow(overflow),
        .raw_out(raw_out)
    );

    // ----------------------------------------------------------------
    // output stage and interrupt gating
    // ----------------------------------------------------------------
    assign nco_out = raw_out ^ output_polarity_q;
    assign nco_pin_o = nco_out;
    assign nco_pin_oe = pin_drive_on_q;
    assign irq_out = overflow_flag_q && module_on_q && overflow_irq_enable_q
        && peripheral_irq_enable_q && global_irq_enable_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_flag_on_ovf: assert property (@(posedge clk_sys) disable iff (!arst_n)
        overflow |=> overflow_flag_q)
        else $error("overflow did not set the flag");
    a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!arst_n)
        overflow_flag_q && !wr_flag |=> overflow_flag_q)
        else $error("flag cleared without a software write");
    a_pol_irq: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_ctrl && overflow_irq_enable_q && reg_wdata[`NCO_BIT_OUTPUT_POLARITY] != output_polarity_q
        |=> overflow_flag_q)
        else $error("polarity change did not set the flag");
    a_irq_gating: assert property (@(posedge clk_sys) disable iff (!arst_n)
        irq_out |-> module_on_q && overflow_irq_enable_q && peripheral_irq_enable_q && global_irq_enable_q)
        else $error("interrupt raised with an enable clear");
    a_status_bit: assert property (@(posedge clk_sys) disable iff (!arst_n)
        reg_rd && reg_addr == `NCO_OFS_CONTROL |=> reg_rdata[`NCO_BIT_OUTPUT_LEVEL] == $past(nco_out))
        else $error("status bit does not show the output level");
    a_unimpl_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
        reg_rd && (reg_addr == `NCO_OFS_CONTROL || reg_addr == `NCO_OFS_CLOCK_CONTROL)
        |=> (($past(reg_addr) == `NCO_OFS_CONTROL) ? (reg_rdata[3:1] == 3'h0)
            : (reg_rdata[4:2] == 3'h0)))
        else $error("unimplemented bits read non-zero");
    a_fast_osc_keep: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_ctrl && reg_wdata[`NCO_BIT_MODULE_ON] && input_clock_select_q == nco_types_pkg::CLK_FAST_OSC
        && !(reg_wr && reg_addr == `NCO_OFS_CLOCK_CONTROL) |=> keep_fast_osc_on)
        else $error("fast oscillator not kept on");
    a_pin_drive: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_ctrl |=> nco_pin_oe == $past(reg_wdata[`NCO_BIT_PIN_DRIVE_ON]))
        else $error("pin drive does not follow its bit");
    a_polarity: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_ctrl && !reg_wdata[`NCO_BIT_MODULE_ON] && !module_on_q
        |=> nco_out == $past(reg_wdata[`NCO_BIT_OUTPUT_POLARITY]))
        else $error("idle output does not follow polarity");

endmodule : nco_output_and_control

/* logic/nco_params.svh */
// register offsets, field positions and reset values of the oscillator block
// assumes an 8-bit register port with a 4-bit word address
`ifndef NCO_PARAMS_SVH
`define NCO_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define NCO_ADDR_W 4
`define NCO_OFS_CONTROL 4'h0
`define NCO_OFS_CLOCK_CONTROL 4'h1
`define NCO_OFS_ACCUM_LOW 4'h2
`define NCO_OFS_ACCUM_HIGH 4'h3
`define NCO_OFS_ACCUM_UPPER 4'h4
`define NCO_OFS_INC_LOW 4'h5
`define NCO_OFS_INC_HIGH 4'h6
`define NCO_OFS_FLAG_REG 4'h7
`define NCO_OFS_ENABLE_REG 4'h8
`define NCO_OFS_IRQ_CONTROL 4'h9

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define NCO_BIT_MODULE_ON 7
`define NCO_BIT_PIN_DRIVE_ON 6
`define NCO_BIT_OUTPUT_LEVEL 5
`define NCO_BIT_OUTPUT_POLARITY 4
`define NCO_BIT_PULSE_MODE 0
`define NCO_PWS_MSB 7
`define NCO_PWS_LSB 5
`define NCO_CKS_MSB 1
`define NCO_CKS_LSB 0
`define NCO_BIT_OVERFLOW_FLAG 4
`define NCO_BIT_OVERFLOW_IE 4
`define NCO_BIT_GLOBAL_IE 7
`define NCO_BIT_PERIPH_IE 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define NCO_RST_BYTE 8'h00
`define NCO_RST_INC 16'h0000

`endif

/* logic/nco_types_pkg.sv */
// types shared by the oscillator block: clock source codes and pulse states
// assumes nothing beyond a SystemVerilog compiler
package nco_types_pkg;

    typedef enum logic [1:0] {
        CLK_EXT_PIN = 2'h0,
        CLK_SYS_OSC = 2'h1,
        CLK_FAST_OSC = 2'h2,
        CLK_LOGIC_CELL = 2'h3
    } clk_sel_e;

    typedef enum logic [1:0] {
        PST_IDLE = 2'h1,
        PST_ACTIVE = 2'h2
    } pulse_state_e;

endpackage : nco_types_pkg

/* logic/nco_accum.sv */
// accumulator, adder and double-buffered increment of the oscillator
// assumes tick is a one-cycle pulse per rising edge of the selected input clock
`timescale 1ns/1ps
module nco_accum #(
    parameter int ACC_W = 20,
    parameter int INC_W = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // control
    input wire logic tick,
    input wire logic module_on,
    input wire logic [INC_W-1:0] inc_value,
    input wire logic inc_arm,
    // byte access to the accumulator
    input wire logic [2:0] acc_wr,
    input wire logic [7:0] acc_wdata,
    // results
    output logic [ACC_W-1:0] acc_value,
    output logic overflow
);

    logic [ACC_W-1:0] acc_q, acc_d;
    logic [INC_W-1:0] buf_q, buf_d;
    logic arm_q, arm_d;
    logic ovf_q, ovf_d;
    logic [ACC_W:0] sum;

    always_comb begin
        sum = (ACC_W+1)'(acc_q) + (ACC_W+1)'(buf_q);
        acc_d = acc_q;
        buf_d = buf_q;
        arm_d = arm_q | inc_arm;
        ovf_d = 1'b0;
        if (!module_on) begin
            buf_d = inc_value;
            arm_d = 1'b0;
        end else if (tick) begin
            acc_d = sum[ACC_W-1:0];
            ovf_d = sum[ACC_W];
            if (arm_q) begin
                buf_d = inc_value;
                arm_d = inc_arm;
            end
        end
        // software byte writes win over the addition in the same cycle
        for (int b = 0; b < ACC_W; b++) begin
            if (acc_wr[b/8]) begin
                acc_d[b] = acc_wdata[b%8];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= '0;
            buf_q <= '0;
            arm_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            buf_q <= buf_d;
            arm_q <= arm_d;
            ovf_q <= ovf_d;
        end
    end

    assign acc_value = acc_q;
    assign overflow = ovf_q;

    a_accum_step: assert property (@(posedge clk_sys) disable iff (!arst_n)
        module_on && tick && acc_wr == 3'h0 |=> acc_q == $past(sum[ACC_W-1:0]) && ovf_q == $past(sum[ACC_W]))
        else $error("accumulator did not add the buffered increment");
    a_accum_low_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        acc_wr[0] |=> acc_q[7:0] == $past(acc_wdata))
        else $error("accumulator low byte write lost");

endmodule : nco_accum

/* logic/nco_pulse.sv */
// output stage before polarity: toggle in fixed duty mode, stretched pulse in pulse mode
// assumes overflow is a one-cycle pulse following the tick that carried out
`timescale 1ns/1ps
module nco_pulse (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // control
    input wire logic tick,
    input wire logic module_on,
    input wire logic pulse_mode_select,
    input wire logic [2:0] pulse_width_select,
    input wire logic overflow,
    // output before polarity
    output logic raw_out
);

    nco_types_pkg::pulse_state_e state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic pend_q, pend_d;
    logic tog_q, tog_d;
    logic raw_q, raw_d;
    logic [7:0] width_m1;

    always_comb begin
        width_m1 = 8'(8'h01 << pulse_width_select) - 8'h01;
        state_d = state_q;
        cnt_d = cnt_q;
        pend_d = pend_q | overflow;
        tog_d = tog_q;
        if (!module_on) begin
            state_d = nco_types_pkg::PST_IDLE;
            cnt_d = 8'h00;
            pend_d = 1'b0;
            tog_d = 1'b0;
        end else if (!pulse_mode_select) begin
            // width select has no effect here
            pend_d = 1'b0;
            state_d = nco_types_pkg::PST_IDLE;
            if (overflow) begin
                tog_d = ~tog_q;
            end
        end else if (tick) begin
            case (state_q)
                nco_types_pkg::PST_IDLE: begin
                    // an overflow seen on the very next tick starts the pulse there
                    if (pend_q || overflow) begin
                        state_d = nco_types_pkg::PST_ACTIVE;
                        cnt_d = width_m1;
                        pend_d = pend_q && overflow;
                    end
                end
                nco_types_pkg::PST_ACTIVE: begin
                    if (cnt_q == 8'h00) begin
                        state_d = nco_types_pkg::PST_IDLE;
                    end else begin
                        cnt_d = cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_d = nco_types_pkg::PST_IDLE;
                end
            endcase
        end
        raw_d = pulse_mode_select ? (state_d == nco_types_pkg::PST_ACTIVE) : tog_d;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= nco_types_pkg::PST_IDLE;
            cnt_q <= 8'h00;
            pend_q <= 1'b0;
            tog_q <= 1'b0;
            raw_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pend_q <= pend_d;
            tog_q <= tog_d;
            raw_q <= raw_d;
        end
    end

    assign raw_out = raw_q;

    a_fdc_toggle: assert property (@(posedge clk_sys) disable iff (!arst_n)
        module_on && !pulse_mode_select && overflow |=> raw_q != $past(raw_q))
        else $error("fixed duty output did not toggle on overflow");
    a_pf_start: assert property (@(posedge clk_sys) disable iff (!arst_n)
        module_on && pulse_mode_select && state_q == nco_types_pkg::PST_IDLE && (pend_q || overflow) && tick
        |=> raw_q)
        else $error("pulse did not start on the tick after overflow");
    a_pf_width_one: assert property (@(posedge clk_sys) disable iff (!arst_n)
        module_on && pulse_mode_select && state_q == nco_types_pkg::PST_ACTIVE && cnt_q == 8'h00 && tick
        |=> !raw_q)
        else $error("pulse outlived its selected width");

endmodule : nco_pulse

/* verif/tb.sv */
// self-checking bench for the oscillator block: registers, clock select, both modes, flag
// assumes the block's register port and one-cycle input-clock ticks on clk_sys
`timescale 1ns/1ps
`include "nco_params.svh"
module tb;
logic clk_sys = 0;
logic arst_n = 0;
logic reg_wr = 0;
logic reg_rd = 0;
logic [3:0] reg_addr = 0;
logic [3:0] tk = 0;
logic [7:0] reg_wdata = 0;
logic [7:0] reg_rdata;
logic [7:0] v;
logic nco_out, nco_pin_o, nco_pin_oe, irq_out, keep_fast_osc_on;
int n_errors = 0;
int check_count = 0;
int cyc = 0;
int hi;
// address, write data, expected read back
logic [19:0] rows [6] = '{20'h00e00, 20'h1ffe3, 20'h2a5a5, 20'hfff00, 20'h01131, 20'h00000};
always #4 clk_sys = ~clk_sys;
nco_output_and_control i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tick_ext_pin(tk[0]), .tick_sys_osc(tk[1]), .tick_fast_osc(tk[2]), .tick_logic_cell(tk[3]),
    .nco_out(nco_out), .nco_pin_o(nco_pin_o), .nco_pin_oe(nco_pin_oe), .irq_out(irq_out),
    .keep_fast_osc_on(keep_fast_osc_on));
task complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask : complete_run
task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
        n_errors++;
        $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
endtask : check
task wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0;
    @(posedge clk_sys);
endtask : wr
task rd(input logic [3:0] a);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 v = reg_rdata;
    @(posedge clk_sys);
endtask : rd
task zero_regs;
    for (int a = 0; a < 3; a++) begin
        rd(4'(a));
        check("reset value", v, 8'h00);
    end
endtask : zero_regs
// accumulator preset one increment below overflow, then enable
task load(input logic [7:0] ck, input logic [7:0] ih, input logic [7:0] ctl);
    wr(`NCO_OFS_CLOCK_CONTROL, ck);
    wr(`NCO_OFS_ACCUM_LOW, 8'h00);
    wr(`NCO_OFS_ACCUM_HIGH, 8'h00 - ih);
    wr(`NCO_OFS_ACCUM_UPPER, 8'h0f);
    wr(`NCO_OFS_INC_HIGH, ih);
    wr(`NCO_OFS_INC_LOW, 8'h00);
    wr(`NCO_OFS_CONTROL, ctl);
endtask : load
task pulse(input logic [3:0] p);
    tk <= p;
    @(posedge clk_sys);
    tk <= 0;
    repeat (3) @(posedge clk_sys);
endtask : pulse
always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
        n_errors++;
        complete_run();
    end
end
initial begin
    repeat (8) @(posedge clk_sys);
    arst_n <= 1;
    @(posedge clk_sys);
    zero_regs();
    foreach (rows[i]) begin
        wr(rows[i][19:16], rows[i][15:8]);
        rd(rows[i][19:16]);
        check("register", v, rows[i][7:0]);
    end
    for (int s = 0; s < 4; s++) begin
        load(8'(s), 8'h80, 8'h80);
        check("keep_fast_osc_on", 8'(keep_fast_osc_on), 8'(s == 2));
        pulse(4'(1 << ((s + 1) % 4)));
        check("nco_out other source", 8'(nco_out), 8'h00);
        pulse(4'(1 << s));
        check("nco_out toggle", 8'(nco_out), 8'h01);
        check("nco_pin_o", 8'(nco_pin_o), 8'h01);
        rd(`NCO_OFS_FLAG_REG);
        check("overflow_flag", v, 8'h10);
        wr(`NCO_OFS_CONTROL, 8'h00);
        wr(`NCO_OFS_FLAG_REG, 8'h00);
    end
    for (int p = 0; p < 8; p++) begin
        load({3'(p), 5'h01}, 8'h10, 8'hc1);
        check("nco_pin_oe", 8'(nco_pin_oe), 8'h01);
        hi = 0;
        tk <= 4'h2;
        repeat (200) begin
            @(posedge clk_sys);
            #1 hi += int'(nco_out);
        end
        @(posedge clk_sys);
        tk <= 0;
        check("pulse width", 8'(hi), 8'(1 << p));
    end
    // running: the low write arms, the next tick still adds the old value and loads 2
    load(8'h01, 8'h00, 8'h80);
    wr(`NCO_OFS_INC_LOW, 8'h02);
    pulse(4'h2);
    pulse(4'h2);
    rd(`NCO_OFS_ACCUM_LOW);
    check("increment buffer", v, 8'h02);
    wr(`NCO_OFS_ENABLE_REG, 8'h10);
    wr(`NCO_OFS_IRQ_CONTROL, 8'hc0);
    check("irq all enabled", 8'(irq_out), 8'h01);
    wr(`NCO_OFS_IRQ_CONTROL, 8'h40);
    check("irq global off", 8'(irq_out), 8'h00);
    wr(`NCO_OFS_IRQ_CONTROL, 8'hc0);
    wr(`NCO_OFS_CONTROL, 8'h41);
    check("irq module off", 8'(irq_out), 8'h00);
    wr(`NCO_OFS_FLAG_REG, 8'h00);
    wr(`NCO_OFS_CONTROL, 8'h51);
    rd(`NCO_OFS_FLAG_REG);
    check("polarity flag", v, 8'h10);
    arst_n <= 0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1;
    @(posedge clk_sys);
    zero_regs();
    complete_run();
end
endmodule : tb
